// File: hw/rmsc_top.sv
// Operating-mode controller: power down, standby-I/II, TX and RX.
// Assumes the modem reports packet events as one-cycle pulses.
//
// What this block does
// - Power-up bit low forces power down; host side keeps working.
// - Powered up with activate low and no retransmit pending, the device sits in standby-I.
// - Activate low during TX or RX returns the device to standby-I.
// - Transmitter, activate high, empty transmit FIFO: standby-II.
// - In standby-II a newly loaded payload starts TX automatically.
// - TX finishes the current packet; activate low then gives standby-I.
// - Activate still high: next packet if queued, else standby-II.
// - Retry from standby-I after the delay while count below limit.
// - Transmitter awaits ack in RX only if auto-ack on, skip-ack clear.
// - Receiver sends ack in TX only if auto-ack on, skip-ack clear.
// - Standby-I goes to RX with power up, receiver role, activate high.
// - Receiver that sent its acknowledgement returns straight to RX.
// - Valid received packet is written to a free receive FIFO slot.
// - Valid packet is dropped when the receive FIFO is full.
// - Receiver leaves RX only for activate low, power down or an ack to send.
// - Carrier detect rises only after signal present 128 us in RX.
// - Auto-ack off means no autonomous switch between TX and RX.
// - Carrier frequency is 2400 MHz plus channel number in 1 MHz steps.
// - Interrupt output is maskable and driven low when active.
// - Transmit-done flag and interrupt after unacked send or received ack.
module rmsc_top (
   // Clock and reset
   input  wire logic                       mclk_in,
   input  wire logic                       rst_in,
   // Configuration
   input  rmsc_pkg::rmsc_cfg_t             cfg_in,
   input  wire logic [rmsc_pkg::CHAN_W-1:0] channel_number_in,
   // Activate pin and FIFO status
   input  wire logic                       chip_enable_in,
   input  wire logic                       tx_fifo_empty_in,
   input  wire logic                       rx_fifo_full_in,
   input  wire logic                       signal_detect_in,
   // Packet events from the modem
   input  rmsc_pkg::rmsc_evt_t             evt_in,
   // Flag control
   input  wire logic                       tx_done_mask_in,
   input  wire logic                       tx_done_clear_in,
   input  wire logic                       max_retry_clear_in,
   // Mode and radio control
   output rmsc_pkg::rmsc_mode_t            mode_out,
   output logic                            tx_start_out,
   output logic                            sending_ack_out,
   output logic                            rx_fifo_write_out,
   output logic                            carrier_detect_out,
   output logic [11:0]                     carrier_freq_mhz_out,
   // Status and interrupt
   output logic [rmsc_pkg::RETRY_W-1:0]    retry_count_out,
   output logic                            transmit_done_flag_out,
   output logic                            max_retry_flag_out,
   output logic                            irq_n_out
);
   // Synchroniser, microsecond tick and activate pulse width
   logic       ce_meta;
   logic       ce_sync;
   logic [7:0] div_cnt;
   logic       us_tick;
   logic [4:0] ce_cnt;
   logic       next_ce_meta;
   logic       next_ce_sync;
   logic [7:0] next_div_cnt;
   logic       next_us_tick;
   logic [4:0] next_ce_cnt;
   logic       ce_long;

   always_comb begin
      next_ce_meta = chip_enable_in;
      next_ce_sync = ce_meta;
      next_us_tick = (div_cnt == rmsc_pkg::US_DIV_LAST);
      next_div_cnt = next_us_tick ? 8'h00 : div_cnt + 8'h01;
      next_ce_cnt  = ce_cnt;
      if (!ce_sync) begin
         next_ce_cnt = 5'h00;
      end else if (us_tick && ce_cnt != rmsc_pkg::CE_CNT_MAX) begin
         next_ce_cnt = ce_cnt + 5'h01;
      end
   end

   // Tick granularity makes the pulse test up to 1 us conservative
   assign ce_long = (ce_cnt > rmsc_pkg::CE_MIN_TICKS);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ce_meta <= 1'b0;
         ce_sync <= 1'b0;
         div_cnt <= 8'h00;
         us_tick <= 1'b0;
         ce_cnt  <= 5'h00;
      end else begin
         ce_meta <= next_ce_meta;
         ce_sync <= next_ce_sync;
         div_cnt <= next_div_cnt;
         us_tick <= next_us_tick;
         ce_cnt  <= next_ce_cnt;
      end
   end

   // Mode state, retransmission, flags and carrier detect
   logic                         await_ack;
   logic                         retry_pending;
   logic [11:0]                  dly_cnt;
   logic [7:0]                   carr_cnt;
   rmsc_pkg::rmsc_mode_t         next_mode;
   logic                         next_await_ack;
   logic                         next_sending_ack;
   logic                         next_retry_pending;
   logic [11:0]                  next_dly_cnt;
   logic [rmsc_pkg::RETRY_W-1:0] next_retry_count;
   logic                         next_tx_start;
   logic                         next_rx_write;
   logic                         next_done_flag;
   logic                         next_max_flag;
   logic [7:0]                   next_carr_cnt;
   logic                         set_done;
   logic                         set_max;
   logic                         pkt_end;

   always_comb begin
      next_mode          = mode_out;
      next_await_ack     = await_ack;
      next_sending_ack   = sending_ack_out;
      next_retry_pending = retry_pending;
      next_dly_cnt       = dly_cnt;
      next_retry_count   = retry_count_out;
      next_tx_start      = 1'b0;
      next_rx_write      = 1'b0;
      set_done           = 1'b0;
      set_max            = 1'b0;
      pkt_end            = 1'b0;
      if (retry_pending && us_tick && dly_cnt != 12'h000) begin
         next_dly_cnt = dly_cnt - 12'h001;
      end
      case (mode_out)
         rmsc_pkg::MODE_PWR_DOWN: begin
            next_mode = rmsc_pkg::MODE_STBY1;
         end
         rmsc_pkg::MODE_STBY1: begin
            if (cfg_in.radio_role_select) begin
               if (ce_sync) begin
                  next_mode = rmsc_pkg::MODE_RX;
               end
            end else if (retry_pending) begin
               if (dly_cnt == 12'h000) begin
                  next_mode          = rmsc_pkg::MODE_TX;
                  next_tx_start      = 1'b1;
                  next_retry_pending = 1'b0;
                  next_retry_count   = retry_count_out + 4'h1;
               end
            end else if (ce_long) begin
               next_retry_count = 4'h0;
               if (!tx_fifo_empty_in) begin
                  next_mode     = rmsc_pkg::MODE_TX;
                  next_tx_start = 1'b1;
               end else begin
                  next_mode = rmsc_pkg::MODE_STBY2;
               end
            end
         end
         rmsc_pkg::MODE_STBY2: begin
            if (!ce_sync) begin
               next_mode = rmsc_pkg::MODE_STBY1;
            end else if (!tx_fifo_empty_in) begin
               next_mode        = rmsc_pkg::MODE_TX;
               next_tx_start    = 1'b1;
               next_retry_count = 4'h0;
            end
         end
         rmsc_pkg::MODE_TX: begin
            // Activate is only looked at once the packet is out
            if (evt_in.tx_sent) begin
               if (sending_ack_out) begin
                  next_sending_ack = 1'b0;
                  next_mode = ce_sync ? rmsc_pkg::MODE_RX
                                      : rmsc_pkg::MODE_STBY1;
               end else if (cfg_in.auto_ack_enable &&
                            !evt_in.tx_skip_ack) begin
                  next_mode      = rmsc_pkg::MODE_RX;
                  next_await_ack = 1'b1;
               end else begin
                  set_done = 1'b1;
                  pkt_end  = 1'b1;
               end
            end
         end
         rmsc_pkg::MODE_RX: begin
            if (!ce_sync) begin
               next_mode      = rmsc_pkg::MODE_STBY1;
               next_await_ack = 1'b0;
            end else if (await_ack) begin
               if (evt_in.ack_received) begin
                  next_await_ack = 1'b0;
                  set_done       = 1'b1;
                  pkt_end        = 1'b1;
               end else if (evt_in.ack_timeout) begin
                  next_await_ack = 1'b0;
                  next_mode      = rmsc_pkg::MODE_STBY1;
                  if (retry_count_out < cfg_in.retransmit_limit) begin
                     next_retry_pending = 1'b1;
                     next_dly_cnt = 12'(rmsc_pkg::DLY_STEP_TICKS *
                        ({8'h00, cfg_in.retransmit_delay} + 12'h001));
                  end else begin
                     set_max = 1'b1;
                  end
               end
            end else if (evt_in.rx_valid) begin
               next_rx_write = !rx_fifo_full_in;
               if (cfg_in.auto_ack_enable &&
                   !evt_in.rx_skip_ack) begin
                  next_mode        = rmsc_pkg::MODE_TX;
                  next_sending_ack = 1'b1;
                  next_tx_start    = 1'b1;
               end
            end
         end
         default: begin
            next_mode = rmsc_pkg::MODE_PWR_DOWN;
         end
      endcase
      if (pkt_end) begin
         if (!ce_sync) begin
            next_mode = rmsc_pkg::MODE_STBY1;
         end else if (!tx_fifo_empty_in) begin
            next_mode        = rmsc_pkg::MODE_TX;
            next_tx_start    = 1'b1;
            next_retry_count = 4'h0;
         end else begin
            next_mode = rmsc_pkg::MODE_STBY2;
         end
      end
      if (!cfg_in.power_up_bit) begin
         next_mode          = rmsc_pkg::MODE_PWR_DOWN;
         next_await_ack     = 1'b0;
         next_sending_ack   = 1'b0;
         next_retry_pending = 1'b0;
         next_tx_start      = 1'b0;
      end
      // Set wins over a clear arriving in the same cycle
      next_done_flag = set_done |
                       (transmit_done_flag_out & ~tx_done_clear_in);
      next_max_flag  = set_max | (max_retry_flag_out & ~max_retry_clear_in);
      next_carr_cnt = carr_cnt;
      if (mode_out != rmsc_pkg::MODE_RX || !signal_detect_in) begin
         next_carr_cnt = 8'h00;
      end else if (us_tick && carr_cnt != rmsc_pkg::CARR_TICKS) begin
         next_carr_cnt = carr_cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mode_out               <= rmsc_pkg::MODE_PWR_DOWN;
         await_ack              <= 1'b0;
         sending_ack_out        <= 1'b0;
         retry_pending          <= 1'b0;
         dly_cnt                <= 12'h000;
         retry_count_out        <= 4'h0;
         tx_start_out           <= 1'b0;
         rx_fifo_write_out      <= 1'b0;
         transmit_done_flag_out <= 1'b0;
         max_retry_flag_out     <= 1'b0;
         irq_n_out              <= 1'b1;
         carr_cnt               <= 8'h00;
         carrier_detect_out     <= 1'b0;
         carrier_freq_mhz_out   <= rmsc_pkg::BASE_FREQ_MHZ;
      end else begin
         mode_out               <= next_mode;
         await_ack              <= next_await_ack;
         sending_ack_out        <= next_sending_ack;
         retry_pending          <= next_retry_pending;
         dly_cnt                <= next_dly_cnt;
         retry_count_out        <= next_retry_count;
         tx_start_out           <= next_tx_start;
         rx_fifo_write_out      <= next_rx_write;
         transmit_done_flag_out <= next_done_flag;
         max_retry_flag_out     <= next_max_flag;
         irq_n_out              <= ~(next_done_flag &
                                     ~tx_done_mask_in);
         carr_cnt               <= next_carr_cnt;
         carrier_detect_out     <= (next_carr_cnt ==
                                    rmsc_pkg::CARR_TICKS);
         carrier_freq_mhz_out   <= rmsc_pkg::BASE_FREQ_MHZ +
                                   {5'h00, channel_number_in};
      end
   end

   // Checks
   localparam int CARR_US_L    = rmsc_pkg::CARR_FILTER_US;
   localparam int CARR_MIN_CYC = (CARR_US_L - 1) * rmsc_pkg::US_CYCLES;
   logic [15:0] sig_cyc;
   always_ff @(posedge mclk_in) begin
      if (rst_in || mode_out != rmsc_pkg::MODE_RX || !signal_detect_in) begin
         sig_cyc <= 16'h0000;
      end else if (sig_cyc != 16'hffff) begin
         sig_cyc <= sig_cyc + 16'h0001;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence ack_sent_s;
      mode_out == rmsc_pkg::MODE_TX && sending_ack_out && evt_in.tx_sent
         && ce_sync && cfg_in.power_up_bit;
   endsequence
   sequence retry_due_s;
      mode_out == rmsc_pkg::MODE_STBY1 && retry_pending && dly_cnt == 12'h000
         && cfg_in.power_up_bit && !cfg_in.radio_role_select;
   endsequence

   power_down_a: assert property (!cfg_in.power_up_bit |=>
      mode_out == rmsc_pkg::MODE_PWR_DOWN && !tx_start_out)
      else $error("not in power down");
   stby1_hold_a: assert property (mode_out == rmsc_pkg::MODE_STBY1
      && !chip_enable_in && !ce_meta && !ce_sync && !retry_pending
      && cfg_in.power_up_bit |=> mode_out == rmsc_pkg::MODE_STBY1)
      else $error("left standby-I with activate low");
   rx_ce_drop_a: assert property (mode_out == rmsc_pkg::MODE_RX
      && !ce_sync && cfg_in.power_up_bit |=>
      mode_out == rmsc_pkg::MODE_STBY1) else $error("rx kept on");
   stby2_load_a: assert property (mode_out == rmsc_pkg::MODE_STBY2
      && ce_sync && !tx_fifo_empty_in && cfg_in.power_up_bit |=>
      mode_out == rmsc_pkg::MODE_TX && tx_start_out)
      else $error("no tx from standby-II");
   tx_finish_a: assert property (mode_out == rmsc_pkg::MODE_TX
      && !evt_in.tx_sent && cfg_in.power_up_bit |=>
      mode_out == rmsc_pkg::MODE_TX) else $error("tx left early");
   ack_wait_a: assert property (mode_out == rmsc_pkg::MODE_TX
      && evt_in.tx_sent && !sending_ack_out && cfg_in.power_up_bit
      && cfg_in.auto_ack_enable && !evt_in.tx_skip_ack |=>
      mode_out == rmsc_pkg::MODE_RX && await_ack)
      else $error("no ack wait");
   retry_go_a: assert property (retry_due_s |=>
      mode_out == rmsc_pkg::MODE_TX && tx_start_out
      && retry_count_out == $past(retry_count_out) + 4'h1)
      else $error("retransmit missed");
   ack_back_a: assert property (ack_sent_s |=>
      mode_out == rmsc_pkg::MODE_RX && !sending_ack_out)
      else $error("no return to rx");
   rx_drop_a: assert property (evt_in.rx_valid && rx_fifo_full_in
      |=> !rx_fifo_write_out) else $error("write into full fifo");
   no_auto_a: assert property (mode_out == rmsc_pkg::MODE_RX
      && !await_ack && !cfg_in.auto_ack_enable |=>
      mode_out != rmsc_pkg::MODE_TX) else $error("autonomous ack");
   carr_filter_a: assert property ($rose(carrier_detect_out) |->
      sig_cyc >= 16'(CARR_MIN_CYC)) else $error("carrier detect early");
   done_irq_a: assert property (mode_out == rmsc_pkg::MODE_TX
      && evt_in.tx_sent && !sending_ack_out && cfg_in.power_up_bit
      && (!cfg_in.auto_ack_enable || evt_in.tx_skip_ack)
      && !tx_done_mask_in |=> transmit_done_flag_out && !irq_n_out)
      else $error("tx done not flagged");
endmodule

// File: hw/rmsc_pkg.sv
// Shared constants and types of the radio mode state controller.
// Assumes a single 250 MHz clock; all timing derives from it.
package rmsc_pkg;
   // Clock and derived microsecond tick
   localparam int CLK_MHZ = 250;
   localparam int US_CYCLES = CLK_MHZ;
   localparam logic [7:0] US_DIV_LAST = 8'(US_CYCLES - 1);
   // Activate pulse must exceed this before a transmission starts
   localparam int CE_MIN_US = 10;
   localparam logic [4:0] CE_MIN_TICKS = 5'(CE_MIN_US);
   localparam logic [4:0] CE_CNT_MAX = 5'h1f;
   // Carrier detect filter time
   localparam int CARR_FILTER_US = 128;
   localparam logic [7:0] CARR_TICKS = 8'(CARR_FILTER_US);
   // Retransmit delay step, per unit of the delay setting
   localparam int DLY_STEP_US = 250;
   localparam logic [11:0] DLY_STEP_TICKS = 12'(DLY_STEP_US);
   // Carrier base frequency and channel step of 1 MHz
   localparam logic [11:0] BASE_FREQ_MHZ = 12'h960;
   localparam int CHAN_W = 7;
   localparam int RETRY_W = 4;

   typedef enum logic [2:0] {
      MODE_PWR_DOWN,
      MODE_STBY1,
      MODE_STBY2,
      MODE_TX,
      MODE_RX
   } rmsc_mode_t;

   typedef struct packed {
      logic               power_up_bit;
      logic               radio_role_select;
      logic               auto_ack_enable;
      logic [RETRY_W-1:0] retransmit_limit;
      logic [RETRY_W-1:0] retransmit_delay;
   } rmsc_cfg_t;

   typedef struct packed {
      logic tx_sent;
      logic ack_received;
      logic ack_timeout;
      logic tx_skip_ack;
      logic rx_valid;
      logic rx_skip_ack;
   } rmsc_evt_t;
endpackage

// File: tb/rmsc_modem_model.sv
// Behavioural modem beside the mode controller: sends packets on request.
// Assumes tx_start and sending_ack come from the controller on one clock.
module rmsc_modem_model #(
   parameter int AIR_CYC = 40,
   parameter int ACK_CYC = 20
) (
   // Clock and reset
   input  wire logic          mclk_in,
   input  wire logic          rst_in,
   // Controller side
   input  wire logic          tx_start_in,
   input  wire logic          sending_ack_in,
   // Scenario settings
   input  wire logic          skip_ack_in,
   input  wire logic [1:0]    ack_kind_in,
   input  wire logic          rx_req_in,
   input  wire logic          rx_skip_in,
   // Events back to the controller
   output rmsc_pkg::rmsc_evt_t evt_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt;
   int   acnt;
   logic busy;
   logic ack_wait;
   logic was_ack;

   always_ff @(posedge mclk_in) begin
      evt_out <= '0;
      evt_out.rx_valid <= rx_req_in;
      evt_out.rx_skip_ack <= rx_skip_in;
      if (rst_in) begin
         busy <= 1'b0;
         ack_wait <= 1'b0;
      end else begin
         if (tx_start_in) begin
            // Air time stays far below the TX limit
            busy <= 1'b1;
            cnt <= AIR_CYC;
            was_ack <= sending_ack_in;
         end else if (busy) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               busy <= 1'b0;
               evt_out.tx_sent <= 1'b1;
               evt_out.tx_skip_ack <= skip_ack_in;
               ack_wait <= !was_ack && ack_kind_in != 2'h0;
               acnt <= ACK_CYC;
            end
         end
         if (ack_wait) begin
            acnt <= acnt - 1;
            if (acnt == 1) begin
               ack_wait <= 1'b0;
               evt_out.ack_received <= ack_kind_in == 2'h1;
               evt_out.ack_timeout <= ack_kind_in == 2'h2;
            end
         end
      end
   end
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the mode controller with a modem model.
// Assumes host settings are plain ports driven on the rising edge.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 mclk_in, rst_in, ce, txe, rxf, sd, mask, dclr;
   logic                 skip, rx_req, rx_skip;
   logic [1:0]           ack_kind;
   logic [6:0]           chan;
   rmsc_pkg::rmsc_cfg_t  cfg;
   rmsc_pkg::rmsc_evt_t  evt;
   rmsc_pkg::rmsc_mode_t mode_out;
   logic                 tx_start, snd_ack, wr, carr, done_f, max_f, irq_n;
   logic [11:0]          freq;
   logic [3:0]           retry;
   int                   n_mismatch, cmp_count, n_wr;

   rmsc_top u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .cfg_in(cfg),
      .channel_number_in(chan), .chip_enable_in(ce), .tx_fifo_empty_in(txe),
      .rx_fifo_full_in(rxf), .signal_detect_in(sd), .evt_in(evt),
      .tx_done_mask_in(mask), .tx_done_clear_in(dclr),
      .max_retry_clear_in(1'b0), .mode_out(mode_out),
      .tx_start_out(tx_start), .sending_ack_out(snd_ack),
      .rx_fifo_write_out(wr), .carrier_detect_out(carr),
      .carrier_freq_mhz_out(freq), .retry_count_out(retry),
      .transmit_done_flag_out(done_f), .max_retry_flag_out(max_f),
      .irq_n_out(irq_n));
   rmsc_modem_model u_modem (.mclk_in(mclk_in), .rst_in(rst_in),
      .tx_start_in(tx_start), .sending_ack_in(snd_ack), .skip_ack_in(skip),
      .ack_kind_in(ack_kind), .rx_req_in(rx_req), .rx_skip_in(rx_skip),
      .evt_out(evt));

   initial begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) if (wr === 1'b1) n_wr++;

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Bounded wait, sampled mid-cycle so edge updates have landed
   task automatic wm(input rmsc_pkg::rmsc_mode_t m, input int n);
      int i;
      @(negedge mclk_in);
      for (i = 0; i < n && mode_out !== m; i++) @(negedge mclk_in);
      chk(12'(mode_out), 12'(m));
   endtask
   task automatic pulse_rx(input logic s);
      cyc(1);
      rx_req <= 1'b1;
      rx_skip <= s;
      cyc(1);
      rx_req <= 1'b0;
      cyc(6);
   endtask

   task automatic t_reset;
      @(negedge mclk_in);
      chk(12'(mode_out), 12'(rmsc_pkg::MODE_PWR_DOWN));
      chk(12'(irq_n), 12'h001);
      chk(freq, 12'h960);
      cyc(1);
      chan <= 7'h51;
      cfg.power_up_bit <= 1'b1;
      cyc(3);
      @(negedge mclk_in);
      chk(freq, 12'h9b1);
      wm(rmsc_pkg::MODE_STBY1, 4);
   endtask
   task automatic t_tx_pulse;
      cyc(1);
      txe <= 1'b0;
      skip <= 1'b1;
      ce <= 1'b1;
      cyc(2250);
      wm(rmsc_pkg::MODE_STBY1, 1);
      wm(rmsc_pkg::MODE_TX, 1000);
      cyc(1);
      ce <= 1'b0;
      cyc(10);
      wm(rmsc_pkg::MODE_TX, 1);
      wm(rmsc_pkg::MODE_STBY1, 100);
      chk(12'(done_f), 12'h001);
      chk(12'(irq_n), 12'h000);
      cyc(1);
      mask <= 1'b1;
      cyc(3);
      @(negedge mclk_in);
      chk(12'(irq_n), 12'h001);
      cyc(1);
      mask <= 1'b0;
      dclr <= 1'b1;
      cyc(1);
      dclr <= 1'b0;
      cyc(2);
      @(negedge mclk_in);
      chk(12'(done_f), 12'h000);
   endtask
   task automatic t_tx_stby2;
      int i;
      cyc(1);
      ce <= 1'b1;
      wm(rmsc_pkg::MODE_TX, 3000);
      for (i = 0; i < 100 && evt.tx_sent !== 1'b1; i++) @(negedge mclk_in);
      cyc(2);
      wm(rmsc_pkg::MODE_TX, 1);
      cyc(1);
      txe <= 1'b1;
      wm(rmsc_pkg::MODE_STBY2, 100);
      cyc(1);
      txe <= 1'b0;
      wm(rmsc_pkg::MODE_TX, 3);
      chk(12'(tx_start), 12'h001);
      cyc(1);
      txe <= 1'b1;
      wm(rmsc_pkg::MODE_STBY2, 100);
   endtask
   task automatic t_ack;
      cyc(1);
      cfg.auto_ack_enable <= 1'b1;
      cfg.retransmit_limit <= 4'h1;
      cfg.retransmit_delay <= 4'h0;
      skip <= 1'b0;
      ack_kind <= 2'h1;
      txe <= 1'b0;
      wm(rmsc_pkg::MODE_TX, 3);
      cyc(1);
      txe <= 1'b1;
      wm(rmsc_pkg::MODE_RX, 100);
      wm(rmsc_pkg::MODE_STBY2, 100);
      chk(12'(done_f), 12'h001);
      cyc(1);
      ack_kind <= 2'h2;
      txe <= 1'b0;
      wm(rmsc_pkg::MODE_TX, 3);
      cyc(1);
      txe <= 1'b1;
      wm(rmsc_pkg::MODE_STBY1, 200);
      cyc(62000);
      wm(rmsc_pkg::MODE_STBY1, 1);
      wm(rmsc_pkg::MODE_TX, 1000);
      chk(12'(retry), 12'h001);
      wm(rmsc_pkg::MODE_STBY1, 200);
      chk(12'(max_f), 12'h001);
   endtask
   task automatic t_rx;
      int w;
      cyc(1);
      ce <= 1'b0;
      txe <= 1'b1;
      cfg.radio_role_select <= 1'b1;
      wm(rmsc_pkg::MODE_STBY1, 10);
      cyc(1);
      ce <= 1'b1;
      wm(rmsc_pkg::MODE_STBY1, 1);
      wm(rmsc_pkg::MODE_RX, 6);
      w = n_wr;
      pulse_rx(1'b0);
      chk(12'(n_wr - w), 12'h001);
      wm(rmsc_pkg::MODE_TX, 1);
      chk(12'(snd_ack), 12'h001);
      wm(rmsc_pkg::MODE_RX, 100);
      cyc(1);
      rxf <= 1'b1;
      pulse_rx(1'b1);
      chk(12'(n_wr - w), 12'h001);
      wm(rmsc_pkg::MODE_RX, 1);
      cyc(1);
      rxf <= 1'b0;
      cfg.auto_ack_enable <= 1'b0;
      pulse_rx(1'b0);
      chk(12'(n_wr - w), 12'h002);
      wm(rmsc_pkg::MODE_RX, 1);
   endtask
   task automatic t_cd;
      cyc(1);
      sd <= 1'b1;
      cyc(31500);
      @(negedge mclk_in);
      chk(12'(carr), 12'h000);
      cyc(1000);
      @(negedge mclk_in);
      chk(12'(carr), 12'h001);
      cyc(1);
      ce <= 1'b0;
      wm(rmsc_pkg::MODE_STBY1, 6);
      cyc(1);
      cfg.power_up_bit <= 1'b0;
      wm(rmsc_pkg::MODE_PWR_DOWN, 3);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Tests take roughly 105k cycles; the limit leaves ample margin
   initial begin
      #800000;
      n_mismatch++;
      summarize();
   end
   initial begin
      n_mismatch = 0;
      cmp_count = 0;
      n_wr = 0;
      rst_in = 1'b1;
      cfg = '0;
      chan = 7'h00;
      {ce, rxf, sd, mask, dclr, skip, rx_req, rx_skip} = '0;
      txe = 1'b1;
      ack_kind = 2'h0;
      cyc(8);
      rst_in <= 1'b0;
      t_reset();
      t_tx_pulse();
      t_tx_stby2();
      t_ack();
      t_rx();
      t_cd();
      summarize();
   end
endmodule
